// ===== inc/kbd_params.svh
// Constants of the keyboard matrix encoder: matrix size, code values, FIFO depth.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef KBD_PARAMS_SVH
`define KBD_PARAMS_SVH

// Matrix geometry
`define KBD_DRIVE_LINES    11
`define KBD_SENSE_LINES    8
`define KBD_LAST_DRIVE     4'hA
`define KBD_LAST_SENSE     3'h7
// Drive index of the first hex line, of the fixed-code line and of the first letter line
`define KBD_HEX_DRIVE      4'h7
`define KBD_FIXED_DRIVE    4'h6
`define KBD_LETTER_DRIVE   4'h2
// Code values
`define KBD_CODE_W         8
`define KBD_HEX_BASE       8'h80
`define KBD_DIGIT_BASE     8'h30
`define KBD_PUNCT_LOW      8'h38
`define KBD_PUNCT_HIGH     8'h28
`define KBD_LETTER_BASE    8'h40
`define KBD_LETTER_LAST    8'h5A
`define KBD_SHIFT_FLIP     8'h10
`define KBD_CASE_BIT       8'h20
`define KBD_CTRL_MASK      8'h1F
`define KBD_CODE_SPACE     8'h20
`define KBD_CODE_LF        8'h0A
`define KBD_CODE_ESC       8'h1B
`define KBD_CODE_CR        8'h0D
`define KBD_CODE_DEL       8'h7F
// Reset values
`define KBD_CODE_RESET     8'h00
// Buffer
`define KBD_FIFO_DEPTH     32

`endif

// ===== inc/kbd_pkg.sv
// Types shared by the keyboard matrix encoder files.
// Assumes nothing of its surroundings.
package kbd_pkg;

   // Controller states, one-hot
   typedef enum logic [4:0] {
      ST_SCAN  = 5'b00001,   // Stepping through the matrix
      ST_CLOSE = 5'b00010,   // Closure found, waiting for settle
      ST_HELD  = 5'b00100,   // Key accepted and still closed
      ST_OPEN  = 5'b01000,   // Key released, waiting for settle
      ST_WAIT  = 5'b10000    // Released, code not yet taken
   } kbd_state_e;

   // Scan position in the matrix
   typedef struct packed {
      logic [3:0] drive;     // Drive index 0..10
      logic [2:0] sense;     // Sense index 0..7
   } scan_pos_s;

   // Modifier levels
   typedef struct packed {
      logic control;
      logic shift;
      logic alpha;
   } mods_s;

endpackage

// ===== rtl/keyboard_matrix_encoder.sv
// Keyboard matrix encoder: scans an 11 x 8 switch matrix and hands codes to a host.
// Assumes all inputs synchronous to mclk; host strobe is sampled, not used as a clock.
`timescale 1ns/1ps
`include "kbd_params.svh"

// Operation
// - Eleven drive outputs, eight sense inputs
// - Sense reads high through closed driven switch
// - Bus driven and flag clear only when selected
// - Bus shows code of scanned key position
// - Key-available goes low on accepted closure
// - Key-available returns high on selected strobe rise
// - Host strobe steps scan and times clearing
// - Repeat flag low while key held after read
// - Release counts only after settle completes
// - Shift and control latched after settle
// - Modifiers alone give no code
// - Letter-lock used live, unlatched
// - Control over shift over alpha priority
// - Drive lines eight to eleven give hex
// - Lines one to seven give ASCII codes
// - Closure freezes scan on strobe rise
// - No new flag until release and closure
// - Scan resumes after release and read
// - Repeat flag ends after release settle
module keyboard_matrix_encoder #(
   parameter int DRIVE_LINES = `KBD_DRIVE_LINES,
   parameter int SENSE_LINES = `KBD_SENSE_LINES,
   parameter int FIFO_DEPTH  = `KBD_FIFO_DEPTH
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_b,
   input  wire logic                   host_timing_strobe,
   output logic [DRIVE_LINES-1:0]      matrix_drive_out,
   input  wire logic [SENSE_LINES-1:0] matrix_sense_in,
   input  wire logic                   select_in_a,
   input  wire logic                   select_in_b,
   input  wire logic                   select_in_c,
   input  wire logic                   select_in_d,
   output logic [`KBD_CODE_W-1:0]      codeBus,
   output logic                        codeBusOe_n,
   output logic                        key_avail_n,
   output logic                        key_held_n,
   input  wire logic                   settleDone,
   input  wire logic                   shiftKey,
   input  wire logic                   controlKey,
   input  wire logic                   letterLock,
   output logic                        fifoInReady
);

   // ****************************************************************
   // Key code encoding
   // ****************************************************************

   // Returns {valid, code} for a position and modifier set
   function automatic logic [8:0] encodeKey(input kbd_pkg::scan_pos_s p, input kbd_pkg::mods_s m);
      logic [7:0] norm;
      logic [7:0] base;
      logic [3:0] off;
      logic       letter;
      norm   = 8'h00;
      base   = 8'h00;
      off    = 4'h0;
      letter = 1'b0;
      encodeKey = 9'h000;
      if (p.drive >= `KBD_HEX_DRIVE) begin
         // Hex lines ignore modifiers
         off = p.drive - `KBD_HEX_DRIVE;
         encodeKey = {1'b1, `KBD_HEX_BASE + {3'b000, off[1:0], p.sense}};
      end else if (p.drive == `KBD_FIXED_DRIVE) begin
         // Fixed control characters, silent elsewhere
         case (p.sense)
            3'h0: encodeKey = {1'b1, `KBD_CODE_SPACE};
            3'h2: encodeKey = {1'b1, `KBD_CODE_LF};
            3'h3: encodeKey = {1'b1, `KBD_CODE_ESC};
            3'h5: encodeKey = {1'b1, `KBD_CODE_CR};
            3'h7: encodeKey = {1'b1, `KBD_CODE_DEL};
            default: encodeKey = 9'h000;
         endcase
      end else if (p.drive < `KBD_LETTER_DRIVE) begin
         // Digits and punctuation; control gives nothing
         if (p.drive == 4'h0) begin
            norm = `KBD_DIGIT_BASE + {5'h00, p.sense};
         end else if (p.sense < 3'h4) begin
            norm = `KBD_PUNCT_LOW + {5'h00, p.sense};
         end else begin
            norm = `KBD_PUNCT_HIGH + {5'h00, p.sense};
         end
         if (m.control) begin
            encodeKey = 9'h000;
         end else if (m.shift) begin
            encodeKey = {1'b1, norm ^ `KBD_SHIFT_FLIP};
         end else begin
            encodeKey = {1'b1, norm};
         end
      end else begin
         // Letter block, four variants
         off    = p.drive - `KBD_LETTER_DRIVE;
         base   = `KBD_LETTER_BASE + {3'b000, off[1:0], p.sense};
         letter = (base != `KBD_LETTER_BASE) && (base <= `KBD_LETTER_LAST);
         if (m.control) begin
            encodeKey = {1'b1, base & `KBD_CTRL_MASK};
         end else if (m.shift) begin
            encodeKey = {1'b1, letter ? base : (base | `KBD_CASE_BIT)};
         end else if (m.alpha) begin
            encodeKey = {1'b1, base};
         end else begin
            encodeKey = {1'b1, letter ? (base | `KBD_CASE_BIT) : base};
         end
      end
   endfunction

   // Next scan position in scan order
   function automatic kbd_pkg::scan_pos_s stepPos(input kbd_pkg::scan_pos_s p);
      stepPos = p;
      if (p.sense == `KBD_LAST_SENSE) begin
         stepPos.sense = 3'h0;
         stepPos.drive = (p.drive == `KBD_LAST_DRIVE) ? 4'h0 : p.drive + 4'h1;
      end else begin
         stepPos.sense = p.sense + 3'h1;
      end
   endfunction

   // ****************************************************************
   // State and decode
   // ****************************************************************

   kbd_pkg::kbd_state_e     state_reg;        // Controller state
   kbd_pkg::kbd_state_e     state_next;       // Its next value
   kbd_pkg::scan_pos_s      pos_reg;          // Current scan position
   kbd_pkg::mods_s          modsEff;          // Modifiers applied to decode
   logic [1:0]              modLatch_reg;     // Latched {control, shift}
   logic                    strobePrev_reg;   // Strobe one cycle ago
   logic                    settleSample_reg; // Settle level at strobe rise
   logic                    settleLow_reg;    // Settle seen low this phase
   logic                    availN_reg;       // Key-available, active low
   logic                    heldN_reg;        // Repeat flag, active low
   logic [`KBD_CODE_W-1:0]  code_reg;         // Code shown to host
   logic                    strobeRise;       // Strobe low to high
   logic                    strobeFall;       // Strobe high to low
   logic                    selectAll;        // All four selects asserted
   logic                    keyHit;           // Sense line at position high
   logic [8:0]              keyCode;          // {valid, code} for position
   logic                    settleOk;         // Settle phase complete
   logic                    pushValid;        // Offer code to the FIFO
   logic [`KBD_CODE_W-1:0]  fifoData;         // Head of FIFO
   logic                    fifoValid;        // FIFO not empty
   logic                    popCode;          // Move head to code register
   logic                    codeTaken;        // Nothing pending for the host
   logic                    clearAvail;       // Host read completes
   logic                    repeatSet;        // Key still held after read

   assign strobeRise  = host_timing_strobe && !strobePrev_reg;
   assign strobeFall  = !host_timing_strobe && strobePrev_reg;
   assign selectAll   = select_in_a && select_in_b && select_in_c && select_in_d;
   assign keyHit      = matrix_sense_in[pos_reg.sense];
   assign modsEff     = '{control: modLatch_reg[1] || controlKey, shift: modLatch_reg[0] || shiftKey,
                          alpha: letterLock};
   assign keyCode     = encodeKey(pos_reg, modsEff);
   assign settleOk    = settleLow_reg && settleSample_reg;
   assign pushValid   = (state_reg == kbd_pkg::ST_CLOSE) && settleOk && keyHit && keyCode[8];
   assign popCode     = fifoValid && availN_reg;
   assign codeTaken   = availN_reg && !fifoValid;
   assign clearAvail  = strobeRise && selectAll;
   assign repeatSet   = (state_reg == kbd_pkg::ST_HELD) && keyHit && codeTaken;
   assign codeBusOe_n = !selectAll;
   assign codeBus     = code_reg;
   assign key_avail_n = availN_reg;
   assign key_held_n  = heldN_reg;

   // One drive line high at the scan position
   genvar gi;
   generate
      for (gi = 0; gi < DRIVE_LINES; gi++) begin : g_drive
         assign matrix_drive_out[gi] = (pos_reg.drive == 4'(gi));
      end
   endgenerate

   // ****************************************************************
   // Controller
   // ****************************************************************

   // Next-state decode
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         kbd_pkg::ST_SCAN: begin
            // First valid closure in scan order wins; freeze on strobe rise
            if (strobeRise && keyHit && keyCode[8]) begin
               state_next = kbd_pkg::ST_CLOSE;
            end
         end
         kbd_pkg::ST_CLOSE: begin
            if (!keyHit) begin
               state_next = kbd_pkg::ST_SCAN;
            end else if (pushValid && fifoInReady) begin
               state_next = kbd_pkg::ST_HELD;
            end
         end
         kbd_pkg::ST_HELD: begin
            if (!keyHit) begin
               state_next = kbd_pkg::ST_OPEN;
            end
         end
         kbd_pkg::ST_OPEN: begin
            // Release valid only once settle completes
            if (keyHit) begin
               state_next = kbd_pkg::ST_HELD;
            end else if (settleOk) begin
               state_next = codeTaken ? kbd_pkg::ST_SCAN : kbd_pkg::ST_WAIT;
            end
         end
         kbd_pkg::ST_WAIT: begin
            if (codeTaken) begin
               state_next = kbd_pkg::ST_SCAN;
            end
         end
         default: state_next = kbd_pkg::ST_SCAN;
      endcase
   end

   // State, strobe history and scan counter
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg      <= kbd_pkg::ST_SCAN;
         strobePrev_reg <= 1'b0;
         pos_reg        <= '0;
      end else begin
         state_reg      <= state_next;
         strobePrev_reg <= host_timing_strobe;
         if ((state_reg == kbd_pkg::ST_SCAN) && strobeFall) begin
            pos_reg <= stepPos(pos_reg);
         end
      end
   end

   // Settle sampling; phase restarts on entry to a settle state
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         settleSample_reg <= 1'b1;
         settleLow_reg    <= 1'b0;
      end else begin
         if (strobeRise) begin
            settleSample_reg <= settleDone;
         end
         if ((state_next != state_reg) &&
             ((state_next == kbd_pkg::ST_CLOSE) || (state_next == kbd_pkg::ST_OPEN))) begin
            settleLow_reg <= 1'b0;
         end else if (!settleSample_reg) begin
            settleLow_reg <= 1'b1;
         end
      end
   end

   // Modifier latch, filled after settle only while hunting a key, so a held modifier cannot leak into the next key
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         modLatch_reg <= 2'b00;
      end else if (pushValid && fifoInReady) begin
         modLatch_reg <= 2'b00;
      end else if (strobeRise && settleDone && (state_reg inside {kbd_pkg::ST_SCAN, kbd_pkg::ST_CLOSE})) begin
         modLatch_reg <= modLatch_reg | {controlKey, shiftKey};
      end
   end

   // Code register and key-available flag; a new code wins over a clear
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         availN_reg <= 1'b1;
         code_reg   <= `KBD_CODE_RESET;
      end else if (popCode) begin
         availN_reg <= 1'b0;
         code_reg   <= fifoData;
      end else if (clearAvail) begin
         availN_reg <= 1'b1;
      end
   end

   // Repeat flag, low while held after read until release settles
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         heldN_reg <= 1'b1;
      end else if (repeatSet) begin
         heldN_reg <= 1'b0;
      end else if ((state_reg == kbd_pkg::ST_OPEN) && !keyHit && settleOk) begin
         heldN_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // Code buffer
   // ****************************************************************

   sync_fifo #(
      .WIDTH (`KBD_CODE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .inData   (keyCode[7:0]),
      .inValid  (pushValid),
      .inReady  (fifoInReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (availN_reg)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************

   property p_drive_onehot;
      @(posedge mclk) disable iff (!rst_b) $onehot(matrix_drive_out);
   endproperty
   a_drive_onehot: assert property (p_drive_onehot) else $error("drive lines not one-hot");

   property p_bus_idle;
      @(posedge mclk) disable iff (!rst_b) codeBusOe_n == !(select_in_a && select_in_b && select_in_c && select_in_d);
   endproperty
   a_bus_idle: assert property (p_bus_idle) else $error("bus driven without select");

   property p_avail_set;
      @(posedge mclk) disable iff (!rst_b) popCode |=> !key_avail_n && (codeBus == $past(fifoData));
   endproperty
   a_avail_set: assert property (p_avail_set) else $error("code not presented with flag");

   property p_avail_clear;
      @(posedge mclk) disable iff (!rst_b) (clearAvail && !popCode) |=> key_avail_n;
   endproperty
   a_avail_clear: assert property (p_avail_clear) else $error("flag not cleared by read");

   property p_freeze;
      @(posedge mclk) disable iff (!rst_b) (state_reg != kbd_pkg::ST_SCAN) |=> $stable(pos_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("scan moved while key pending");

   property p_no_second;
      @(posedge mclk) disable iff (!rst_b) (state_reg == kbd_pkg::ST_HELD) && codeTaken |=> key_avail_n;
   endproperty
   a_no_second: assert property (p_no_second) else $error("second code while held");

   property p_hex;
      @(posedge mclk) disable iff (!rst_b) (pushValid && (pos_reg.drive >= `KBD_HEX_DRIVE)) |->
         keyCode[7:0] == (`KBD_HEX_BASE + 8'((pos_reg.drive - `KBD_HEX_DRIVE) * 8) + 8'(pos_reg.sense));
   endproperty
   a_hex: assert property (p_hex) else $error("hex code wrong");

   property p_ctrl;
      @(posedge mclk) disable iff (!rst_b) (pushValid && modsEff.control && (pos_reg.drive < `KBD_FIXED_DRIVE))
         |-> keyCode[7:5] == 3'h0;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control code out of range");

   property p_repeat;
      @(posedge mclk) disable iff (!rst_b) repeatSet |=> !key_held_n [*1] ##1 (!key_held_n || !keyHit);
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeat flag not held");

   property p_scan_step;
      @(posedge mclk) disable iff (!rst_b) ((state_reg == kbd_pkg::ST_SCAN) && strobeFall) |=> $changed(pos_reg);
   endproperty
   a_scan_step: assert property (p_scan_step) else $error("scan did not step");

   c_push:   cover property (@(posedge mclk) disable iff (!rst_b) pushValid && fifoInReady);
   c_read:   cover property (@(posedge mclk) disable iff (!rst_b) clearAvail && !key_avail_n);
   c_repeat: cover property (@(posedge mclk) disable iff (!rst_b) $fell(key_held_n));
   c_resume: cover property (@(posedge mclk) disable iff (!rst_b) (state_reg == kbd_pkg::ST_WAIT) ##[1:50]
                             (state_reg == kbd_pkg::ST_SCAN));
endmodule

// ===== rtl/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];     // Storage array
   logic [AW:0]      wrPtr_reg;       // Write pointer with wrap bit
   logic [AW:0]      rdPtr_reg;       // Read pointer with wrap bit
   logic             doWrite;         // Word taken this cycle
   logic             doRead;          // Word given this cycle
   logic             isEmpty;         // No words stored
   logic             isFull;          // All entries used

   // Status decode
   assign isEmpty  = (wrPtr_reg == rdPtr_reg);
   assign isFull   = (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]) && (wrPtr_reg[AW] != rdPtr_reg[AW]);
   assign inReady  = !isFull;
   assign outValid = !isEmpty;
   assign doWrite  = inValid && !isFull;
   assign doRead   = outReady && !isEmpty;
   assign outData  = mem[rdPtr_reg[AW-1:0]];

   // Storage write
   always_ff @(posedge mclk) begin
      if (doWrite) begin
         mem[wrPtr_reg[AW-1:0]] <= inData;
      end
   end

   // Pointer update
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end else begin
         if (doWrite) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (doRead) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
      end
   end
endmodule

// ===== tb/host_model.sv
// Host model: makes the timing strobe, drives the selects and reads the code bus.
// Assumes mclk from the bench; selects active high, all four high means selected.
`timescale 1ns/1ps
module host_model (
   input  wire logic       mclk,
   input  wire logic [7:0] codeBus,
   input  wire logic       codeBusOe_n,
   output logic            strobe,
   output logic [3:0]      sel,
   output logic [7:0]      got,
   output logic            gotValid,
   output logic            oeSeen
);
   // ****************
   // Strobe generator
   // ****************
   logic [2:0] phase;   // Strobe phase, four cycles low then four high
   initial begin
      phase = 3'h0;
      strobe = 1'b0;
      sel = 4'h0;
      got = 8'h00;
      gotValid = 1'b0;
      oeSeen = 1'b1;
   end
   // Free-running strobe steps the scan and times the flag clear
   always @(posedge mclk) begin
      phase <= phase + 3'h1;
      strobe <= phase[2];
   end
   // Input cycle: selects held across a whole strobe pulse, code taken at the rise
   task automatic read(input logic [3:0] mask);
      do @(posedge mclk); while (phase != 3'h1);
      sel <= mask;
      do @(posedge mclk); while (phase != 3'h4);
      got <= codeBus;
      oeSeen <= codeBusOe_n;
      gotValid <= &mask;
      @(posedge mclk);
      gotValid <= 1'b0;
      do @(posedge mclk); while (phase != 3'h0);
      sel <= 4'h0;
   endtask
endmodule

// ===== tb/keyboard_matrix_encoder_bench.sv
// Bench for the keyboard encoder: key matrix, settle level and host reads.
// Assumes the host model file and the kbd_pkg package are compiled first.
`timescale 1ns/1ps
module keyboard_matrix_encoder_bench;
   // *******
   // Signals
   // *******
   logic           mclk, rst_b, settleDone, keyOn, strobe, gotValid, oeSeen;
   logic           codeBusOe_n, key_avail_n, key_held_n, fifoInReady;
   logic [3:0]     keyDrive, sel;
   logic [2:0]     keySense;
   logic [7:0]     got, codeBus, sense, r;
   logic [10:0]    driveOut;
   kbd_pkg::mods_s mods;   // Modifier levels
   logic [7:0]     q[$];   // Expected codes
   int             num_errors, comparisons, seed, i;
   // One closed switch joins its drive line to its sense line, others pulled low
   assign sense = (keyOn && driveOut[keyDrive]) ? (8'h01 << keySense) : 8'h00;
   keyboard_matrix_encoder i_dut (
      .mclk(mclk), .rst_b(rst_b), .host_timing_strobe(strobe), .matrix_drive_out(driveOut),
      .matrix_sense_in(sense), .select_in_a(sel[0]), .select_in_b(sel[1]), .select_in_c(sel[2]),
      .select_in_d(sel[3]), .codeBus(codeBus), .codeBusOe_n(codeBusOe_n), .key_avail_n(key_avail_n),
      .key_held_n(key_held_n), .settleDone(settleDone), .shiftKey(mods.shift),
      .controlKey(mods.control), .letterLock(mods.alpha), .fifoInReady(fifoInReady));
   host_model i_host (
      .mclk(mclk), .codeBus(codeBus), .codeBusOe_n(codeBusOe_n), .strobe(strobe), .sel(sel),
      .got(got), .gotValid(gotValid), .oeSeen(oeSeen));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Compare and count
   task automatic check(input logic [10:0] seen, input logic [10:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Settle level dips for three strobes then returns, pull-up idles it high
   task automatic settle;
      repeat (24) @(posedge mclk);
      settleDone <= 1'b0;
      repeat (24) @(posedge mclk);
      settleDone <= 1'b1;
      repeat (24) @(posedge mclk);
   endtask
   // Whole key cycle: press, refused read, read, hold, release; early releases before the read
   task automatic press(input logic [3:0] d, input logic [2:0] s, input logic [2:0] m,
                        input logic [7:0] exp, input logic early);
      int n;
      keyDrive <= d;
      keySense <= s;
      mods <= kbd_pkg::mods_s'(m);
      keyOn <= 1'b1;
      repeat (800) @(posedge mclk);
      check(driveOut, 11'h001 << d);
      settle();
      n = 0;
      while (key_avail_n !== 1'b0 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      mods <= 3'b000;
      check(key_avail_n, 1'b0);
      // Early release leaves the code pending and the repeat flag high
      if (early) begin
         keyOn <= 1'b0;
         settle();
         check({key_avail_n, key_held_n}, 2'b01);
      end
      i_host.read(4'h7);
      check({oeSeen, key_avail_n}, 2'b10);
      q.push_back(exp);
      i_host.read(4'hF);
      check(oeSeen, 1'b0);
      repeat (24) @(posedge mclk);
      check({key_avail_n, key_held_n, fifoInReady}, {1'b1, early, 1'b1});
      keyOn <= 1'b0;
      settle();
      check(key_held_n, 1'b1);
      $display("key %0h done", exp);
   endtask
   // Results seen by the host are matched against the oldest note
   always @(posedge mclk) begin
      if (gotValid === 1'b1) begin
         check(got, q.pop_front());
      end
   end
   // Watchdog well above the expected run length
   initial begin
      repeat (40000) @(posedge mclk);
      num_errors++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      rst_b = 1'b0;
      settleDone = 1'b1;
      keyOn = 1'b0;
      keyDrive = 4'h0;
      keySense = 3'h0;
      mods = 3'b000;
      seed = 5289;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      press(4'h2, 3'h1, 3'b000, 8'h61, 1'b0);
      press(4'h2, 3'h1, 3'b001, 8'h41, 1'b0);
      press(4'h2, 3'h2, 3'b000, 8'h62, 1'b1);
      for (i = 0; i < 5; i++) begin
         r = 8'($random(seed));
         press(4'h6, 3'(40'h0002030507 >> (8 * (4 - i))), r[7:5],
               8'(40'h200A1B0D7F >> (8 * (4 - i))), 1'b0);
      end
      for (i = 0; i < 4; i++) begin
         r = 8'($random(seed));
         press(4'h7 + {2'h0, r[1:0]}, r[4:2], r[7:5], {3'b100, r[1:0], r[4:2]}, 1'b0);
      end
      press(4'h2, 3'h1, 3'b010, 8'h41, 1'b0);
      press(4'h2, 3'h1, 3'b110, 8'h01, 1'b0);
      tally_and_finish();
   end
endmodule
